// file: verilog/ttav_consts.vh
// register map, field positions and reset values of the trip/alarm block
`ifndef TTAV_CONSTS_VH
`define TTAV_CONSTS_VH
`define TTAV_NCH 11
`define TTAV_NGRP 3
`define TTAV_NUNIT 14
`define TTAV_NVOTE 2
`define TTAV_AW 8
`define TTAV_OFS_CTRL 8'h00
`define TTAV_OFS_CH_EN 8'h04
`define TTAV_OFS_ALM_EN 8'h08
`define TTAV_OFS_DELAY 8'h0c
`define TTAV_OFS_VOTE0 8'h10
`define TTAV_OFS_VOTE1 8'h14
`define TTAV_OFS_IRQ_STAT 8'h18
`define TTAV_OFS_IRQ_CLR 8'h1c
`define TTAV_OFS_IRQ_EN 8'h20
`define TTAV_OFS_STATUS 8'h24
`define TTAV_OFS_TRIP_VEC 8'h28
`define TTAV_OFS_TOUT_VEC 8'h2c
`define TTAV_OFS_THR_BASE 8'h40
`define TTAV_OFS_THR_LAST 8'h74
`define TTAV_CTRL_GLOB_EN 0
`define TTAV_CTRL_SRC_SEL 1
`define TTAV_VOTE_ACT 0
`define TTAV_VOTE_N_LO 4
`define TTAV_VOTE_N_HI 7
`define TTAV_VOTE_M_LO 16
`define TTAV_VOTE_M_HI 26
`define TTAV_EV_FINAL 0
`define TTAV_EV_TOUT 1
`define TTAV_EV_ALARM 2
`define TTAV_EV_VOTE0 3
`define TTAV_EV_VOTE1 4
`define TTAV_NEV 5
`define TTAV_GRP_WIND 11'h03f
`define TTAV_GRP_AMB 11'h0c0
`define TTAV_GRP_AUX 11'h700
`define TTAV_CTRL_RST 2'h0
`define TTAV_DELAY_RST 32'h000f4240
`define TTAV_THR_RST 32'h0000_0000
`define TTAV_RESP_OK 2'h0
`define TTAV_RESP_ERR 2'h2
`endif

// file: verilog/ttav_trip_alarm.v
// temperature trip, delayed alarm and k-of-n voting with axi4-lite regs
`timescale 1ns/1ps
`include "ttav_consts.vh"

// How it works
// R01: eleven temperature channels, each evaluated by its own logic.
// R02: trip follows the trip threshold with no added delay.
// R03: timeout alarm rises after alarm level held for the delay count.
// R04: each alarm has its own enable bit.
// R05: trip and alarm drop only below threshold times 0.99.
// R06: global enable and per-channel enables gate the whole function.
// R07: each group evaluates the hottest enabled channel in it.
// R08: a voting scheme is idle unless its activation bit is set.
// R09: vote trip when selected tripping channels reach the vote count.
// R10: per-scheme member mask picks which channels are counted.
// R11: a channel counts only when it and the global enable are on.
// R12: vote trips reach the final trip only with source select set.
// R13: two vote trip outputs are provided for tripping use.
// R14: collective alarm, timeout and trip are ORs over all channels and groups.
// R15: collective timeout ORs channel and group timeouts.
// R16: source select picks OR of channel and group trips or OR of vote trips.
// R17: block-trip input suppresses every channel trip.
// R18: alarm delay timer restarts when alarm drops before expiry.
module ttav_trip_alarm #(
  parameter TW = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [`TTAV_NCH*TW-1:0] temp_in,
  input wire block_trip,
  output wire [`TTAV_NCH-1:0] ch_trip,
  output wire [`TTAV_NCH-1:0] ch_alarm,
  output wire [`TTAV_NCH-1:0] ch_timeout,
  output wire [`TTAV_NGRP-1:0] grp_trip,
  output wire [`TTAV_NGRP-1:0] grp_alarm,
  output wire [`TTAV_NGRP-1:0] grp_timeout,
  output wire any_alarm,
  output wire any_timeout,
  output wire any_trip,
  output wire [`TTAV_NVOTE-1:0] vote_trip,
  output wire final_trip,
  output wire irq,
  input wire [`TTAV_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`TTAV_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  localparam NU = `TTAV_NUNIT;
  localparam NC = `TTAV_NCH;

  // hysteresis compare: pick above thr, hold down to 0.99 * thr
  function hyst;
    input st;
    input [TW-1:0] t;
    input [TW-1:0] thr;
    reg [TW+6:0] a;
    reg [TW+6:0] b;
    begin
      a = {7'h00, t};
      b = {7'h00, thr};
      a = (a << 6) + (a << 5) + (a << 2);
      b = (b << 6) + (b << 5) + (b << 1) + b;
      hyst = st ? (a >= b) : (t > thr);
    end
  endfunction

  // hottest enabled channel inside a mask
  function [TW-1:0] hottest;
    input [NC*TW-1:0] t;
    input [NC-1:0] m;
    integer k;
    begin
      hottest = {TW{1'b0}};
      for (k = 0; k < NC; k = k + 1) begin
        if (m[k] && t[k*TW +: TW] > hottest) begin
          hottest = t[k*TW +: TW];
        end
      end
    end
  endfunction

  function [3:0] popcnt;
    input [NC-1:0] v;
    integer k;
    begin
      popcnt = 4'h0;
      for (k = 0; k < NC; k = k + 1) begin
        popcnt = popcnt + {3'h0, v[k]};
      end
    end
  endfunction

  // software state
  reg [1:0] ctrl_q;
  reg [NC-1:0] ch_en_q;
  reg [NU-1:0] alm_en_q;
  reg [31:0] delay_q;
  reg [31:0] vote_cfg_q [0:`TTAV_NVOTE-1];
  reg [31:0] thr_q [0:NU-1];
  reg [`TTAV_NEV-1:0] irq_stat_q;
  reg [`TTAV_NEV-1:0] irq_en_q;

  // evaluation state
  reg [NU-1:0] trip_q;
  reg [NU-1:0] alm_q;
  reg [NU-1:0] tout_q;
  reg [31:0] cnt_q [0:NU-1];
  reg any_alarm_q;
  reg any_tout_q;
  reg any_trip_q;
  reg [`TTAV_NVOTE-1:0] vote_q;
  reg final_q;

  wire glob_en = ctrl_q[`TTAV_CTRL_GLOB_EN];
  wire src_sel = ctrl_q[`TTAV_CTRL_SRC_SEL];
  wire [NC-1:0] ch_live = ch_en_q & {NC{glob_en}}; // R06 R11
  wire [NC-1:0] grp_mask [0:`TTAV_NGRP-1];
  assign grp_mask[0] = `TTAV_GRP_WIND;
  assign grp_mask[1] = `TTAV_GRP_AMB;
  assign grp_mask[2] = `TTAV_GRP_AUX;

  genvar i;
  generate
    for (i = 0; i < NU; i = i + 1) begin : g_unit
      wire [TW-1:0] ut;
      wire uen;
      wire trip_nx;
      wire alm_nx;
      if (i < NC) begin : g_ch
        assign ut = temp_in[i*TW +: TW]; // R01
        assign uen = ch_live[i]; // R06
      end else begin : g_grp
        assign ut = hottest(temp_in, ch_live & grp_mask[i-NC]); // R07
        assign uen = |(ch_live & grp_mask[i-NC]);
      end
      // R02 R05 R17
      assign trip_nx = uen & ~block_trip &
        hyst(trip_q[i], ut, thr_q[i][TW-1:0]);
      // R04 R05
      assign alm_nx = uen & alm_en_q[i] &
        hyst(alm_q[i], ut, thr_q[i][16 +: TW]);
      always @(posedge aclk) begin
        if (!aresetn) begin
          trip_q[i] <= 1'b0;
          alm_q[i] <= 1'b0;
          tout_q[i] <= 1'b0;
          cnt_q[i] <= 32'h0000_0000;
        end else if (ce) begin
          trip_q[i] <= trip_nx;
          alm_q[i] <= alm_nx;
          if (!alm_nx) begin
            cnt_q[i] <= 32'h0000_0000; // R18
          end else if (cnt_q[i] < delay_q) begin
            cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
          end
          tout_q[i] <= alm_nx && (cnt_q[i] >= delay_q); // R03
        end
      end
    end
  endgenerate

  // voting and collective signals, one register stage
  reg [`TTAV_NVOTE-1:0] vote_d;
  reg final_d;
  integer v;
  always @* begin
    vote_d = {`TTAV_NVOTE{1'b0}};
    for (v = 0; v < `TTAV_NVOTE; v = v + 1) begin
      // R08 R09 R10 R11
      vote_d[v] = vote_cfg_q[v][`TTAV_VOTE_ACT] &&
        (vote_cfg_q[v][`TTAV_VOTE_N_HI:`TTAV_VOTE_N_LO] != 4'h0) &&
        (popcnt(trip_q[NC-1:0] & ch_live &
          vote_cfg_q[v][`TTAV_VOTE_M_HI:`TTAV_VOTE_M_LO]) >=
          vote_cfg_q[v][`TTAV_VOTE_N_HI:`TTAV_VOTE_N_LO]);
    end
    final_d = src_sel ? |vote_d : |trip_q; // R12 R16
  end

  wire any_alarm_d = |alm_q; // R14
  wire any_tout_d = |tout_q; // R14 R15
  wire any_trip_d = |trip_q; // R14
  wire [`TTAV_NEV-1:0] ev = {vote_d & ~vote_q,
    any_alarm_d & ~any_alarm_q, any_tout_d & ~any_tout_q,
    final_d & ~final_q};

  always @(posedge aclk) begin
    if (!aresetn) begin
      any_alarm_q <= 1'b0;
      any_tout_q <= 1'b0;
      any_trip_q <= 1'b0;
      vote_q <= {`TTAV_NVOTE{1'b0}};
      final_q <= 1'b0;
    end else if (ce) begin
      any_alarm_q <= any_alarm_d;
      any_tout_q <= any_tout_d;
      any_trip_q <= any_trip_d;
      vote_q <= vote_d; // R13
      final_q <= final_d;
    end
  end

  assign ch_trip = trip_q[NC-1:0];
  assign ch_alarm = alm_q[NC-1:0];
  assign ch_timeout = tout_q[NC-1:0];
  assign grp_trip = trip_q[NU-1:NC];
  assign grp_alarm = alm_q[NU-1:NC];
  assign grp_timeout = tout_q[NU-1:NC];
  assign any_alarm = any_alarm_q;
  assign any_timeout = any_tout_q;
  assign any_trip = any_trip_q;
  assign vote_trip = vote_q;
  assign final_trip = final_q;
  assign irq = |(irq_stat_q & irq_en_q);

  // axi4-lite write side: address and data may arrive in any order
  reg aw_hold_q;
  reg w_hold_q;
  reg [`TTAV_AW-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  assign s_axi_awready = ce & ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ce & ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_hold_q | aw_hs;
  wire w_have = w_hold_q | w_hs;
  wire do_wr = aw_have & w_have & ~bvalid_q & ce;
  wire [`TTAV_AW-1:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd_raw = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // merged words cut back to the register widths on purpose
  wire [31:0] ch_en_m = merge({21'h0, ch_en_q}, wd_raw, wmask);
  wire [31:0] alm_en_m = merge({18'h0, alm_en_q}, wd_raw, wmask);
  wire [31:0] irq_en_m = merge({27'h0, irq_en_q}, wd_raw, wmask);

  function is_thr;
    input [`TTAV_AW-1:0] a;
    begin
      is_thr = (a >= `TTAV_OFS_THR_BASE) && (a <= `TTAV_OFS_THR_LAST);
    end
  endfunction

  function wr_ok;
    input [`TTAV_AW-1:0] a;
    begin
      case (a)
        `TTAV_OFS_CTRL, `TTAV_OFS_CH_EN, `TTAV_OFS_ALM_EN,
        `TTAV_OFS_DELAY, `TTAV_OFS_VOTE0, `TTAV_OFS_VOTE1,
        `TTAV_OFS_IRQ_CLR, `TTAV_OFS_IRQ_EN: wr_ok = 1'b1;
        default: wr_ok = is_thr(a);
      endcase
    end
  endfunction

  wire [3:0] widx = wa[5:2];
  wire [31:0] clr = (do_wr && wa == `TTAV_OFS_IRQ_CLR) ?
    (wd_raw & wmask) : 32'h0000_0000;

  integer r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {`TTAV_AW{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `TTAV_RESP_OK;
      ctrl_q <= `TTAV_CTRL_RST;
      ch_en_q <= {NC{1'b0}};
      alm_en_q <= {NU{1'b0}};
      delay_q <= `TTAV_DELAY_RST;
      irq_en_q <= {`TTAV_NEV{1'b0}};
      irq_stat_q <= {`TTAV_NEV{1'b0}};
      for (r = 0; r < `TTAV_NVOTE; r = r + 1) begin
        vote_cfg_q[r] <= 32'h0000_0000;
      end
      for (r = 0; r < NU; r = r + 1) begin
        thr_q[r] <= `TTAV_THR_RST;
      end
    end else if (ce) begin
      // set wins over clear for every sticky event bit
      irq_stat_q <= (irq_stat_q & ~clr[`TTAV_NEV-1:0]) | ev;
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok(wa) ? `TTAV_RESP_OK : `TTAV_RESP_ERR;
        case (wa)
          `TTAV_OFS_CTRL:
            ctrl_q <= wd_raw[1:0] & wmask[1:0] | ctrl_q & ~wmask[1:0];
          `TTAV_OFS_CH_EN:
            ch_en_q <= ch_en_m[NC-1:0];
          `TTAV_OFS_ALM_EN:
            alm_en_q <= alm_en_m[NU-1:0];
          `TTAV_OFS_DELAY:
            delay_q <= merge(delay_q, wd_raw, wmask);
          `TTAV_OFS_VOTE0:
            vote_cfg_q[0] <= merge(vote_cfg_q[0], wd_raw, wmask);
          `TTAV_OFS_VOTE1:
            vote_cfg_q[1] <= merge(vote_cfg_q[1], wd_raw, wmask);
          `TTAV_OFS_IRQ_EN:
            irq_en_q <= irq_en_m[`TTAV_NEV-1:0];
          default: begin
            if (is_thr(wa)) begin
              thr_q[widx] <= merge(thr_q[widx], wd_raw, wmask);
            end
          end
        endcase
      end else begin
        if (aw_hs) begin
          aw_hold_q <= 1'b1;
        end
        if (w_hs) begin
          w_hold_q <= 1'b1;
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read side: one outstanding read, data registered
  reg [31:0] rd_d;
  reg [1:0] rr_d;
  always @* begin
    rr_d = `TTAV_RESP_OK;
    case (s_axi_araddr)
      `TTAV_OFS_CTRL: rd_d = {30'h0, ctrl_q};
      `TTAV_OFS_CH_EN: rd_d = {21'h0, ch_en_q};
      `TTAV_OFS_ALM_EN: rd_d = {18'h0, alm_en_q};
      `TTAV_OFS_DELAY: rd_d = delay_q;
      `TTAV_OFS_VOTE0: rd_d = vote_cfg_q[0];
      `TTAV_OFS_VOTE1: rd_d = vote_cfg_q[1];
      `TTAV_OFS_IRQ_STAT: rd_d = {27'h0, irq_stat_q};
      `TTAV_OFS_IRQ_CLR: rd_d = 32'h0000_0000;
      `TTAV_OFS_IRQ_EN: rd_d = {27'h0, irq_en_q};
      `TTAV_OFS_STATUS: rd_d = {26'h0, vote_q, final_q, any_trip_q,
        any_tout_q, any_alarm_q};
      `TTAV_OFS_TRIP_VEC: rd_d = {18'h0, trip_q};
      `TTAV_OFS_TOUT_VEC: rd_d = {2'h0, tout_q, 2'h0, alm_q};
      default: begin
        if (is_thr(s_axi_araddr)) begin
          rd_d = thr_q[s_axi_araddr[5:2]];
        end else begin
          rd_d = 32'h0000_0000;
          rr_d = `TTAV_RESP_ERR;
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `TTAV_RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_d;
        rresp_q <= rr_d;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

// file: verif/ttav_trip_alarm_assertions.sv
// assertion checker for the temperature trip and alarm block
`timescale 1ns/1ps
`include "ttav_consts.vh"
module ttav_chk (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire block_trip,
  input wire [`TTAV_NCH-1:0] ch_trip,
  input wire [`TTAV_NCH-1:0] ch_alarm,
  input wire [`TTAV_NCH-1:0] ch_timeout,
  input wire [`TTAV_NGRP-1:0] grp_trip,
  input wire [`TTAV_NGRP-1:0] grp_alarm,
  input wire [`TTAV_NGRP-1:0] grp_timeout,
  input wire any_alarm,
  input wire any_timeout,
  input wire any_trip,
  input wire [`TTAV_NVOTE-1:0] vote_trip,
  input wire final_trip
);
  wire u_trip = |{ch_trip, grp_trip};
  wire u_alm = |{ch_alarm, grp_alarm};
  wire u_tout = |{ch_timeout, grp_timeout};
  wire c_trip = |ch_trip;
  wire v_any = |vote_trip;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  blk_trip_a: assert property (block_trip && ce |=> ch_trip == 0)
    else $error("channel trip while blocked");
  any_trip_a: assert property (ce |=> any_trip == $past(u_trip))
    else $error("collective trip mismatch");
  any_alm_a: assert property (ce |=> any_alarm == $past(u_alm))
    else $error("collective alarm mismatch");
  any_tout_a: assert property (ce |=> any_timeout == $past(u_tout))
    else $error("collective timeout mismatch");
  tout_alm_a: assert property ((ch_timeout & ~ch_alarm) == 0)
    else $error("timeout without alarm");
  tout_dly_a: assert property ($rose(ch_timeout[0]) |->
    $past(ch_alarm[0], 4) && !$past(ch_alarm[0], 5))
    else $error("timeout delay wrong");
  vote_src_a: assert property (v_any |-> $past(c_trip))
    else $error("vote trip without channel trip");
  final_src_a: assert property (final_trip |->
    any_trip || v_any || $past(v_any))
    else $error("final trip without source");
endmodule
bind ttav_trip_alarm ttav_chk u_chk (.aclk, .aresetn, .ce, .block_trip,
  .ch_trip, .ch_alarm, .ch_timeout, .grp_trip, .grp_alarm, .grp_timeout,
  .any_alarm, .any_timeout, .any_trip, .vote_trip, .final_trip);

// file: verif/ttav_rtd_src.sv
// acquisition module model: holds one temperature word per channel
`timescale 1ns/1ps
`include "ttav_consts.vh"
module ttav_rtd_src (
  input wire aclk,
  input wire ld,
  input wire [3:0] ch,
  input wire [15:0] val,
  output reg [`TTAV_NCH*16-1:0] temp_in
);
  initial temp_in = '0;
  // a new reading lands on a clock edge, as a frame would
  always @(posedge aclk) begin
    if (ld) temp_in[ch*16+:16] <= val;
  end
endmodule

// file: verif/testbench.sv
// self-checking testbench of the temperature trip and alarm block
`timescale 1ns/1ps
`include "ttav_consts.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  err_total++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic aclk = 0, aresetn = 0, blk = 0, ld = 0, ce = 1;
  logic [3:0] ch = 0;
  logic [15:0] val = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] rsp;
  wire awready, wready, bvalid, arready, rvalid, any_trip, final_trip, irq;
  wire [1:0] bresp, rresp, vote_trip;
  wire [31:0] rdata;
  wire [`TTAV_NCH*16-1:0] temp;
  wire [10:0] ch_trip, ch_alarm, ch_timeout;
  wire [2:0] grp_trip;
  int err_total = 0, compares = 0;
  initial forever #2.5 aclk = ~aclk;
  ttav_rtd_src src (.aclk(aclk), .ld(ld), .ch(ch), .val(val),
    .temp_in(temp));
  // wstrb tied: byte lanes are left untested
  ttav_trip_alarm dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .temp_in(temp), .block_trip(blk), .ch_trip(ch_trip),
    .ch_alarm(ch_alarm), .ch_timeout(ch_timeout), .grp_trip(grp_trip),
    .grp_alarm(), .grp_timeout(), .any_alarm(), .any_timeout(),
    .any_trip(any_trip), .vote_trip(vote_trip), .final_trip(final_trip),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task tmo(input logic ok);
    if (!ok) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task tmp(input int c, input int v);
    @(posedge aclk);
    ld <= 1;
    ch <= c[3:0];
    val <= v[15:0];
    @(posedge aclk);
    ld <= 0;
  endtask
  // handshakes judged mid-cycle, released just after the taking edge
  task wr(input [7:0] a, input [31:0] d);
    logic ta, tw, tk;
    tk = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !tk; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    bready <= 0;
    tmo(tk);
  endtask
  task rdr(input [7:0] a);
    logic ta, tk;
    tk = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !tk; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tk = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end
    rready <= 0;
    tmo(tk);
  endtask
  task t_init;
    rdr(8'h0c);
    `CHK("delay reset", `TTAV_DELAY_RST, rd);
    rdr(8'h30);
    `CHK("unmapped resp", 2'h2, rsp);
    `CHK("unmapped data", 32'h0, rd);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h7ff);
    wr(8'h08, 32'h3fff);
    wr(8'h0c, 32'h4);
    wr(8'h20, 32'h1f);
    // alarm level 100 in the high half, trip level 200 in the low half
    for (int u = 0; u < 14; u++) wr(8'h40 + 8'(4 * u), 32'h0064_00c8);
    wr(8'h18, 32'h0);
    `CHK("read-only write resp", 2'h2, rsp);
    rdr(8'h00);
    `CHK("ctrl", 32'h1, rd);
    $display("test init done");
  endtask
  task t_trip;
    tmp(3, 201);
    wt(1);
    `CHK("ch_trip", 11'h008, ch_trip);
    wt(1);
    `CHK("grp_trip", 3'h1, grp_trip);
    `CHK("any_trip", 1'b1, any_trip);
    `CHK("final_trip", 1'b1, final_trip);
    tmp(3, 198);
    wt(3);
    `CHK("held trip", 11'h008, ch_trip);
    tmp(3, 197);
    wt(3);
    `CHK("dropped trip", 11'h000, ch_trip);
    rdr(8'h18);
    `CHK("irq stat", 32'h7, rd);
    `CHK("irq", 1'b1, irq);
    wr(8'h20, 32'h0);
    wt(1);
    `CHK("irq masked", 1'b0, irq);
    wr(8'h20, 32'h1f);
    wr(8'h1c, 32'h1f);
    wt(1);
    `CHK("irq cleared", 1'b0, irq);
    tmp(3, 50);
    $display("test trip done");
  endtask
  task t_tout;
    tmp(0, 150);
    wt(4);
    `CHK("timeout early", 1'b0, ch_timeout[0]);
    wt(1);
    `CHK("timeout", 1'b1, ch_timeout[0]);
    tmp(0, 50);
    wt(2);
    `CHK("timeout drop", 1'b0, ch_timeout[0]);
    tmp(0, 150);
    wt(4);
    `CHK("timer restart", 1'b0, ch_timeout[0]);
    wt(1);
    `CHK("timeout again", 1'b1, ch_timeout[0]);
    wr(8'h08, 32'h3ffe);
    wt(2);
    `CHK("alarm off", 2'h0, {ch_alarm[0], ch_timeout[0]});
    wr(8'h08, 32'h3fff);
    tmp(0, 50);
    $display("test timeout done");
  endtask
  task t_vote;
    wr(8'h10, 32'h0007_0021);
    wr(8'h14, 32'h0100_0010);
    wr(8'h00, 32'h3);
    tmp(0, 201);
    tmp(8, 201);
    wt(3);
    `CHK("one vote", 2'h0, vote_trip);
    `CHK("final idle", 1'b0, final_trip);
    tmp(1, 201);
    wt(3);
    `CHK("two votes", 2'h1, vote_trip);
    `CHK("final vote", 1'b1, final_trip);
    wr(8'h04, 32'h7fd);
    wt(3);
    `CHK("disabled member", 2'h0, vote_trip);
    wr(8'h14, 32'h0100_0011);
    wt(3);
    `CHK("second scheme", 2'h2, vote_trip);
    $display("test vote done");
  endtask
  task t_block;
    wr(8'h00, 32'h1);
    @(posedge aclk);
    blk <= 1;
    wt(2);
    `CHK("blocked", 11'h000, ch_trip);
    @(posedge aclk);
    blk <= 0;
    wt(2);
    `CHK("live channels", 11'h101, ch_trip);
    wr(8'h00, 32'h0);
    wt(3);
    `CHK("global off", 11'h000, ch_trip);
    `CHK("global off vote", 2'h0, vote_trip);
    $display("test block done");
  endtask
  // clock enable low must freeze the trip state
  task t_freeze;
    wr(8'h00, 32'h1);
    wt(3);
    @(posedge aclk);
    ce <= 0;
    tmp(0, 50);
    wt(3);
    `CHK("frozen trip", 11'h101, ch_trip);
    @(posedge aclk);
    ce <= 1;
    wt(3);
    `CHK("thawed trip", 11'h100, ch_trip);
    $display("test freeze done");
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_init;
    t_trip;
    t_tout;
    t_vote;
    t_block;
    t_freeze;
    tally_and_finish;
  end
endmodule
